//--- hdl/aac_pkg.sv
// Purpose: Shared constants for the converter acquisition control block.
// Assumes: 250 MHz system clock, byte-wide host I/O port.
// Notes: Offsets are byte offsets within the card's I/O window.
package aac_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CONV_NS = 8000;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int FIFO_DEPTH = 2048;
    localparam int FIFO_HALF = FIFO_DEPTH / 2;
    localparam int RES_W = 12;
    // Register offsets.
    localparam logic [3:0] OFS_DATA_LO = 4'h0;
    localparam logic [3:0] OFS_DATA_HI = 4'h1;
    localparam logic [3:0] OFS_ADC_CTL = 4'h2;
    localparam logic [3:0] OFS_SUBMUX = 4'h3;
    localparam logic [3:0] OFS_OPTION = 4'h4;
    localparam logic [3:0] OFS_DIO = 4'h5;
    localparam logic [3:0] OFS_PLIST = 4'h6;
    localparam logic [3:0] OFS_PLCLR = 4'h7;
    // Field positions and widths.
    localparam int OPT_IRQ_EN = 0;
    localparam int OPT_SRC_LSB = 1;
    localparam int OPT_BUF_EN = 3;
    localparam int CTL_DIFF = 4;
    localparam int CTL_RNG_LSB = 5;
    localparam int SUB_GAIN_LSB = 4;
    localparam int CTR_SEL_LSB = 6;
    localparam int CTR_MODE_BIT = 0;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Conversion start sources.
    typedef enum logic [1:0] {
        AAC_SRC_SW = 2'b00,
        AAC_SRC_EXT = 2'b01,
        AAC_SRC_PACE = 2'b10,
        AAC_SRC_ALL = 2'b11
    } aac_src_e;
endpackage : aac_pkg

//--- hdl/aac_ctr_if.sv
// Purpose: Carries counter register access and counter events.
// Assumes: One clock domain shared by both ends.
// Notes: The top drives the access side, the counter block answers.
interface aac_ctr_if;
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ext_clk;
    logic gate;
    logic pace;
    logic out0;
    modport host (output wr, rd, addr, wdata, ext_clk, gate, input rdata, pace, out0);
    modport ctr (input wr, rd, addr, wdata, ext_clk, gate, output rdata, pace, out0);
endinterface : aac_ctr_if

//--- hdl/aac_counters.sv
// Purpose: Three 16-bit down counters, 1 and 2 cascaded as the pacer.
// Assumes: External counter clock is synchronous and slower than clock/2.
// Notes: Byte writes load low then high; reads return low then high.
module aac_counters
    import aac_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Register and event carrier.
    aac_ctr_if.ctr bus
);
    logic [15:0] cnt_q [3]; // Live counts.
    logic [15:0] rld_q [3]; // Reload values.
    logic [2:0] mode_q; // One bit per counter: set for reload.
    logic [2:0] whi_q; // Next write goes to the high byte.
    logic [2:0] rhi_q; // Next read returns the high byte.
    logic [7:0] tick_q; // Divider for the 1 MHz time base.
    logic ext_q; // Last sample of the external clock.
    logic [2:0] dec; // Decrement strobes.
    logic [2:0] tc; // Terminal count strobes.
    logic out0_q;
    logic pace_q;

    // The 1 MHz time base; its falling edge is the tick.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tick_q <= '0;
        else if (tick_q == 8'(TICK_CYC - 1))
            tick_q <= '0;
        else
            tick_q <= tick_q + 8'h01;
    end

    // Falling edge sampler for the external counter clock.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ext_q <= 1'b0;
        else
            ext_q <= bus.ext_clk;
    end

    // Counter 0 counts falling edges while its gate pin is high.
    assign dec[0] = ext_q && !bus.ext_clk && bus.gate;
    assign dec[1] = (tick_q == 8'(TICK_CYC - 1));
    assign dec[2] = dec[1] && (cnt_q[1] == 16'h0001);
    assign tc[0] = dec[0] && (cnt_q[0] == 16'h0001);
    assign tc[1] = dec[2];
    assign tc[2] = dec[2] && (cnt_q[2] == 16'h0001);

    // Count, reload and byte loading; a load outranks a count.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cnt_q[i] <= RST_WORD;
                rld_q[i] <= RST_WORD;
            end
            whi_q <= '0;
            mode_q <= '0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (dec[i] && tc[i] && mode_q[i])
                    cnt_q[i] <= rld_q[i];
                else if (dec[i])
                    cnt_q[i] <= cnt_q[i] - 16'h0001;
            end
            if (bus.wr && bus.addr == 2'h3 && bus.wdata[CTR_SEL_LSB +: 2] != 2'h3)
            begin
                mode_q[bus.wdata[CTR_SEL_LSB +: 2]] <= bus.wdata[CTR_MODE_BIT];
                whi_q[bus.wdata[CTR_SEL_LSB +: 2]] <= 1'b0;
            end
            else if (bus.wr && bus.addr != 2'h3)
            begin
                whi_q[bus.addr] <= !whi_q[bus.addr];
                if (whi_q[bus.addr])
                begin
                    rld_q[bus.addr][15:8] <= bus.wdata;
                    cnt_q[bus.addr] <= {bus.wdata, rld_q[bus.addr][7:0]};
                end
                else
                    rld_q[bus.addr][7:0] <= bus.wdata;
            end
        end
    end

    // Read side: alternate low and high bytes of the live count.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rhi_q <= '0;
        else if (bus.rd && bus.addr != 2'h3)
            rhi_q[bus.addr] <= !rhi_q[bus.addr];
    end

    always_comb
    begin
        bus.rdata = {5'h00, mode_q};
        if (bus.addr != 2'h3)
            bus.rdata = rhi_q[bus.addr] ? cnt_q[bus.addr][15:8] : cnt_q[bus.addr][7:0];
    end

    // Outputs: counter 0 toggles at terminal, pacer pulses per cascade wrap.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            out0_q <= 1'b0;
            pace_q <= 1'b0;
        end
        else
        begin
            if (tc[0])
                out0_q <= !out0_q;
            pace_q <= tc[2];
        end
    end
    assign bus.out0 = out0_q;
    assign bus.pace = pace_q;

    property p_pace;
        @(posedge clock) disable iff (rst) tc[2] |=> pace_q;
    endproperty
    a_pace: assert property (p_pace) else $error("pacer pulse missing");

    property p_tick_gap;
        @(posedge clock) disable iff (rst) dec[1] |=> !dec[1] [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too fast");

    property p_cascade;
        @(posedge clock) disable iff (rst)
            dec[1] && cnt_q[1] != 16'h0001 |=> $stable(cnt_q[2]) || $past(bus.wr);
    endproperty
    a_cascade: assert property (p_cascade) else $error("counter 2 moved early");
endmodule : aac_counters

//--- hdl/aac_top.sv
// Purpose: Acquisition control for a 12-bit converter card on a host I/O port.
// Assumes: Host strobes are one cycle wide and synchronous to clock.
// Notes: Read data appears on io_rdata_q one cycle after io_rd.
// Notes on behaviour
// - Start from software, pacer or external trigger.
// - Report completion by flag and optional interrupt.
// - Buffered mode: 2K sample and point lists.
// - Expose FIFO fill flags; interrupt on them.
// - Offset 3 holds submux select and gain.
// - Submux select tags top four result bits.
// - Three 16-bit down counters.
// - Counter 0 gated by pin, external clock.
// - Counters 1 and 2 cascade on 1 MHz.
// - Cascaded counter output can start conversions.
// - Counters support counting and waveform generation.
// - One interrupt, software enabled, EOC or FIFO.
// - Results are 12-bit binary.
// - Conversion done within 8 microseconds.
// - Counters step on falling clock edge.
// - Four digital inputs and four outputs.
// - Buffered: point list picks channels, FIFO stores.
// - Eight differential or sixteen single-ended channels.
// - Write to offset 0 starts conversion.
// - Reading offset 4 clears pending interrupt.
module aac_top
    import aac_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Host I/O port.
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata_q,
    output logic irq_q,
    // Converter and front end.
    output logic adc_convert_q,
    output logic [3:0] adc_mux_q,
    output logic adc_diff_q,
    output logic [2:0] adc_range_q,
    input wire logic [11:0] adc_result,
    input wire logic ext_trigger,
    // Submultiplexer drive.
    output logic [3:0] submux_channel_select_q,
    output logic [2:0] submux_gain_select_q,
    // Counter pins.
    input wire logic counter_zero_gate_pin,
    input wire logic counter_zero_gate_pin_clk,
    output logic counter_zero_gate_pin_out_q,
    // General purpose digital I/O.
    output logic [3:0] dig_out_q,
    input wire logic [3:0] dig_in
);
    aac_ctr_if cif ();

    logic [7:0] adc_ctl_q; // Channel, input mode and range.
    logic [7:0] option_q; // Interrupt enable, start source, buffer enable.
    logic trig_q; // Last external trigger level.
    logic [10:0] conv_cnt_q; // Cycles into the current conversion.
    logic eoc_q; // Result ready.
    logic [15:0] res_q; // Tagged result word.
    logic pend_q; // Interrupt pending.
    logic ovf_q; // Sample dropped on a full FIFO.
    logic [15:0] fifo_mem [FIFO_DEPTH]; // Sample store.
    logic [10:0] f_wr_q;
    logic [10:0] f_rd_q;
    logic [11:0] f_cnt_q;
    logic [4:0] pl_mem [FIFO_DEPTH]; // Point list: mode bit and channel.
    logic [10:0] pl_wr_q; // Entries written.
    logic [10:0] pl_rd_q; // Next entry to use.
    logic sel_io; // Access to a card register below the counters.
    logic start_req;
    logic start_go;
    logic done;
    logic f_push;
    logic f_pop;
    logic f_full;
    logic f_half;
    logic buf_en;
    aac_src_e src;

    // Channel decode: differential mode uses only the low three bits.
    function automatic logic [3:0] chan_decode(input logic diff, input logic [3:0] ch);
        chan_decode = diff ? {1'b0, ch[2:0]} : ch;
    endfunction : chan_decode

    assign sel_io = !io_addr[3];
    assign buf_en = option_q[OPT_BUF_EN];
    assign src = aac_src_e'(option_q[OPT_SRC_LSB +: 2]);
    assign f_full = (f_cnt_q == 12'(FIFO_DEPTH));
    assign f_half = (f_cnt_q >= 12'(FIFO_HALF));
    assign done = adc_convert_q && (conv_cnt_q == 11'(CONV_CYC - 1));
    assign f_push = done && buf_en && !f_full;
    assign f_pop = io_rd && sel_io && io_addr == OFS_DATA_HI && buf_en && f_cnt_q != 12'h000;

    // Any of the three sources may request a conversion.
    always_comb
    begin
        start_req = io_wr && sel_io && io_addr == OFS_DATA_LO;
        if ((src == AAC_SRC_EXT || src == AAC_SRC_ALL) && ext_trigger && !trig_q)
            start_req = 1'b1;
        if ((src == AAC_SRC_PACE || src == AAC_SRC_ALL) && cif.pace)
            start_req = 1'b1;
    end
    assign start_go = start_req && !adc_convert_q;

    // Counter block access through the carrier.
    assign cif.wr = io_wr && io_addr[3];
    assign cif.rd = io_rd && io_addr[3];
    assign cif.addr = io_addr[1:0];
    assign cif.wdata = io_wdata;
    assign cif.ext_clk = counter_zero_gate_pin_clk;
    assign cif.gate = counter_zero_gate_pin;

    aac_counters u_ctr (
        .clock(clock),
        .rst(rst),
        .bus(cif)
    );

    // Host-writable control registers.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            adc_ctl_q <= RST_BYTE;
            option_q <= RST_BYTE;
            submux_channel_select_q <= '0;
            submux_gain_select_q <= '0;
            dig_out_q <= '0;
        end
        else if (io_wr && sel_io)
        begin
            unique case (io_addr)
                OFS_ADC_CTL: adc_ctl_q <= io_wdata;
                OFS_OPTION: option_q <= io_wdata;
                OFS_SUBMUX:
                begin
                    submux_channel_select_q <= io_wdata[3:0];
                    submux_gain_select_q <= io_wdata[SUB_GAIN_LSB +: 3];
                end
                OFS_DIO: dig_out_q <= io_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Trigger edge detector.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            trig_q <= 1'b0;
        else
            trig_q <= ext_trigger;
    end

    // Conversion timing and front-end selection.
    // Channel and input mode come from the point list when buffering is on and the list holds entries; range always comes from adc_ctl_q.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            adc_convert_q <= 1'b0;
            conv_cnt_q <= '0;
            adc_mux_q <= '0;
            adc_diff_q <= 1'b0;
            adc_range_q <= '0;
        end
        else if (start_go)
        begin
            adc_convert_q <= 1'b1;
            conv_cnt_q <= '0;
            adc_range_q <= adc_ctl_q[CTL_RNG_LSB +: 3];
            if (buf_en && pl_wr_q != 11'h000)
            begin
                adc_diff_q <= pl_mem[pl_rd_q][4];
                adc_mux_q <= chan_decode(pl_mem[pl_rd_q][4], pl_mem[pl_rd_q][3:0]);
            end
            else
            begin
                adc_diff_q <= adc_ctl_q[CTL_DIFF];
                adc_mux_q <= chan_decode(adc_ctl_q[CTL_DIFF], adc_ctl_q[3:0]);
            end
        end
        else if (done)
            adc_convert_q <= 1'b0;
        else if (adc_convert_q)
            conv_cnt_q <= conv_cnt_q + 11'h001;
    end

    // Result latch with the submux select as tag; EOC drops on start.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            eoc_q <= 1'b0;
            res_q <= RST_WORD;
        end
        else if (start_go)
            eoc_q <= 1'b0;
        else if (done)
        begin
            eoc_q <= 1'b1;
            res_q <= {submux_channel_select_q, adc_result};
        end
    end

    // Point list: host pushes entries, each buffered conversion start steps round them.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pl_wr_q <= '0;
            pl_rd_q <= '0;
        end
        else if (io_wr && sel_io && io_addr == OFS_PLCLR)
        begin
            pl_wr_q <= '0;
            pl_rd_q <= '0;
        end
        else
        begin
            if (io_wr && sel_io && io_addr == OFS_PLIST && pl_wr_q != 11'h7FF)
                pl_wr_q <= pl_wr_q + 11'h001;
            if (start_go && buf_en && pl_wr_q != 11'h000)
                pl_rd_q <= (pl_rd_q + 11'h001 == pl_wr_q) ? 11'h000 : pl_rd_q + 11'h001;
        end
    end

    // Point list storage; an array write with no reset.
    always_ff @(posedge clock)
    begin
        if (io_wr && sel_io && io_addr == OFS_PLIST)
            pl_mem[pl_wr_q] <= io_wdata[4:0];
    end

    // Sample FIFO storage.
    always_ff @(posedge clock)
    begin
        if (f_push)
            fifo_mem[f_wr_q] <= {submux_channel_select_q, adc_result};
    end

    // Sample FIFO pointers and fill count.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            f_wr_q <= '0;
            f_rd_q <= '0;
            f_cnt_q <= '0;
        end
        else
        begin
            if (f_push)
                f_wr_q <= f_wr_q + 11'h001;
            if (f_pop)
                f_rd_q <= f_rd_q + 11'h001;
            if (f_push && !f_pop)
                f_cnt_q <= f_cnt_q + 12'h001;
            else if (f_pop && !f_push)
                f_cnt_q <= f_cnt_q - 12'h001;
        end
    end

    // Overflow and pending flags; a new event beats a status read.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ovf_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            if (done && buf_en && f_full)
                ovf_q <= 1'b1;
            else if (io_rd && sel_io && io_addr == OFS_OPTION)
                ovf_q <= 1'b0;
            if (done && (!buf_en || f_full || f_cnt_q == 12'(FIFO_HALF - 1)))
                pend_q <= 1'b1;
            else if (io_rd && sel_io && io_addr == OFS_OPTION)
                pend_q <= 1'b0;
        end
    end

    // Interrupt line only when software enables it.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= pend_q && option_q[OPT_IRQ_EN];
    end

    // Counter 0 output pin.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            counter_zero_gate_pin_out_q <= 1'b0;
        else
            counter_zero_gate_pin_out_q <= cif.out0;
    end

    // Read multiplexer; FIFO head is returned in buffered mode.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            io_rdata_q <= RST_BYTE;
        else if (io_rd && !sel_io)
            io_rdata_q <= cif.rdata;
        else if (io_rd)
        begin
            unique case (io_addr)
                OFS_DATA_LO: io_rdata_q <= buf_en ? fifo_mem[f_rd_q][7:0] : res_q[7:0];
                OFS_DATA_HI: io_rdata_q <= buf_en ? fifo_mem[f_rd_q][15:8] : res_q[15:8];
                OFS_ADC_CTL: io_rdata_q <= adc_ctl_q;
                OFS_SUBMUX: io_rdata_q <= {1'b0, submux_gain_select_q, submux_channel_select_q};
                OFS_OPTION: io_rdata_q <= {2'b00, ovf_q, f_full, f_half, f_cnt_q == 12'h000,
                                           pend_q, eoc_q};
                OFS_DIO: io_rdata_q <= {4'h0, dig_in};
                default: io_rdata_q <= RST_BYTE;
            endcase
        end
    end

    property p_conv_time;
        @(posedge clock) disable iff (rst) $fell(adc_convert_q) |-> $past(conv_cnt_q) == 11'(CONV_CYC - 1);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    // The ready flag drops with the start and rises only as the busy line falls.
    property p_eoc_clear;
        @(posedge clock) disable iff (rst) adc_convert_q |-> !eoc_q;
    endproperty
    a_eoc_clear: assert property (p_eoc_clear) else $error("result flag set while busy");

    property p_busy_ignore;
        @(posedge clock) disable iff (rst) adc_convert_q && !done |=> conv_cnt_q == $past(conv_cnt_q) + 11'h001;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("start accepted while busy");

    property p_tag;
        @(posedge clock) disable iff (rst) done && !start_go |=> res_q[15:12] == $past(submux_channel_select_q);
    endproperty
    a_tag: assert property (p_tag) else $error("result tag wrong");

    property p_ovf;
        @(posedge clock) disable iff (rst)
            done && buf_en && f_full |=> ovf_q && $stable(f_wr_q) && (f_full || $past(f_pop));
    endproperty
    a_ovf: assert property (p_ovf) else $error("full FIFO not protected");

    property p_irq_clear;
        @(posedge clock) disable iff (rst)
            io_rd && sel_io && io_addr == OFS_OPTION && !done |=> !pend_q ##1 !irq_q;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status read left irq");

    property p_irq_en;
        @(posedge clock) disable iff (rst) !option_q[OPT_IRQ_EN] |=> !irq_q;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while disabled");

    property p_sw_start;
        @(posedge clock) disable iff (rst)
            io_wr && sel_io && io_addr == OFS_DATA_LO && !adc_convert_q |=> adc_convert_q && !eoc_q;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start ignored");
endmodule : aac_top

//--- tb/aac_adc_model.sv
// Purpose: Converter stand-in that presents a result while converting.
// Assumes: The convert line is registered on the rising clock edge.
// Notes: Outside a conversion the output changes every cycle.
module aac_adc_model #(
    parameter logic [11:0] VALUE = 12'hA5C
)
(
    // Clock and converter handshake.
    input wire logic clock,
    input wire logic convert,
    output logic [11:0] result
);
    timeunit 1ns;
    timeprecision 1ps;

    // Hold the sample during a conversion; toggle otherwise, so that
    // stale data differs from a fresh result on at least every other cycle.
    initial result = 12'h000;
    always @(posedge clock)
    begin
        if (convert)
            result <= VALUE;
        else
            result <= ~result;
    end
endmodule : aac_adc_model

//--- tb/adc_acquisition_control_test.sv
// Purpose: Self-checking bench for the acquisition control block.
// Assumes: Inputs change at the falling clock edge only.
// Notes: Counter 0 pins are driven by the bench; the pacer time base runs free.
module adc_acquisition_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aac_pkg::*;

    logic clock = 0, rst = 1, io_wr = 0, io_rd = 0, ext_trigger = 0;
    logic [3:0] io_addr = 4'h0, dig_in = 4'h9, dig_out_q, adc_mux_q, sel_q;
    logic [7:0] io_wdata = 8'h00, io_rdata_q, d;
    logic [11:0] adc_result;
    logic [2:0] adc_range_q, gain_q;
    logic irq_q, adc_convert_q, adc_diff_q, counter_zero_gate_pin_out_q;
    logic gate = 0, cclk = 0;
    int errors = 0, cmp_count = 0, n;

    // Free-running 250 MHz clock.
    always #2 clock = ~clock;

    aac_top dut (.clock(clock), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .irq_q(irq_q),
        .adc_convert_q(adc_convert_q), .adc_mux_q(adc_mux_q), .adc_diff_q(adc_diff_q),
        .adc_range_q(adc_range_q), .adc_result(adc_result), .ext_trigger(ext_trigger),
        .submux_channel_select_q(sel_q), .submux_gain_select_q(gain_q),
        .counter_zero_gate_pin(gate), .counter_zero_gate_pin_clk(cclk), .counter_zero_gate_pin_out_q(counter_zero_gate_pin_out_q),
        .dig_out_q(dig_out_q), .dig_in(dig_in));
    aac_adc_model adc (.clock(clock), .convert(adc_convert_q), .result(adc_result));

    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clock);
        io_addr = a;
        io_wdata = v;
        io_wr = 1;
        @(negedge clock);
        io_wr = 0;
    endtask : wr

    // One-cycle read strobe; data is registered at the strobe's edge.
    task automatic rd(input logic [3:0] a);
        @(negedge clock);
        io_addr = a;
        io_rd = 1;
        @(negedge clock);
        io_rd = 0;
        d = io_rdata_q;
    endtask : rd

    // Bounded wait for the converter to go idle; n counts busy cycles.
    task automatic wait_idle;
        n = 0;
        while (adc_convert_q === 1'b1 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
    endtask : wait_idle

    // External counter clock: k full periods, ending low.
    task automatic pulse(input int k);
        repeat (k)
        begin
            @(negedge clock) cclk = 1;
            @(negedge clock) cclk = 0;
        end
    endtask : pulse

    // Software start, busy refusal, tagged result and status flags.
    task automatic t_soft;
        wr(OFS_SUBMUX, 8'h5B);
        chk("sel", 4'hB, sel_q);
        chk("gain", 3'h5, gain_q);
        wr(OFS_ADC_CTL, 8'hBF);
        wr(OFS_DATA_LO, 8'h00);
        chk("busy", 1'b1, adc_convert_q);
        chk("range", 3'h5, adc_range_q);
        chk("mux", 4'h7, adc_mux_q);
        chk("diff", 1'b1, adc_diff_q);
        wr(OFS_DATA_LO, 8'h33);
        rd(OFS_OPTION);
        chk("eoc_busy", 1'b0, d[0]);
        wait_idle();
        chk("conv_len", 12'd1996, n);
        rd(OFS_OPTION);
        chk("eoc", 2'b11, d[1:0]);
        chk("irq_masked", 1'b0, irq_q);
        rd(OFS_DATA_LO);
        chk("lo", 8'h5C, d);
        rd(OFS_DATA_HI);
        chk("hi", 8'hBA, d);
    endtask : t_soft

    // Buffered mode: point-list channel, FIFO store, fill flags and pop.
    task automatic t_buf;
        rd(OFS_OPTION);
        wr(OFS_PLIST, 8'h13);
        wr(OFS_OPTION, 8'h08);
        wr(OFS_DATA_LO, 8'h00);
        chk("pl_mux", 4'h3, adc_mux_q);
        wait_idle();
        rd(OFS_OPTION);
        chk("buf_stat", 6'h01, d[5:0]);
        rd(OFS_DATA_LO);
        chk("buf_lo", 8'h5C, d);
        rd(OFS_DATA_HI);
        chk("buf_hi", 8'hBA, d);
        rd(OFS_OPTION);
        chk("buf_empty", 6'h05, d[5:0]);
        wr(OFS_OPTION, 8'h00);
    endtask : t_buf

    // Counter 0 counts falling external edges only while its gate is high.
    task automatic t_ctr;
        wr(4'h8, 8'h02);
        wr(4'h8, 8'h00);
        pulse(1);
        rd(4'h8);
        chk("ctr_gated", 8'h02, d);
        rd(4'h8);
        chk("ctr_hi", 8'h00, d);
        gate = 1;
        pulse(2);
        repeat (2) @(negedge clock);
        chk("ctr_out", 1'b1, counter_zero_gate_pin_out_q);
        gate = 0;
    endtask : t_ctr

    // The cascaded pair paces one conversion after two 1 MHz ticks.
    task automatic t_pace;
        wr(OFS_OPTION, 8'h04);
        wr(4'hA, 8'h01);
        wr(4'hA, 8'h00);
        wr(4'h9, 8'h02);
        wr(4'h9, 8'h00);
        n = 0;
        while (adc_convert_q !== 1'b1 && n < 600)
        begin
            @(negedge clock);
            n++;
        end
        chk("pace_start", 1'b1, adc_convert_q);
        chk("pace_time", 1'b1, n >= TICK_CYC && n <= 2 * TICK_CYC + 2);
        wait_idle();
    endtask : t_pace

    // Enabled interrupt follows completion and is cleared by a status read.
    task automatic t_irq;
        wr(OFS_OPTION, 8'h01);
        wr(OFS_DATA_LO, 8'h00);
        wait_idle();
        repeat (2) @(negedge clock);
        chk("irq_set", 1'b1, irq_q);
        rd(OFS_OPTION);
        chk("pend", 1'b1, d[1]);
        @(negedge clock);
        chk("irq_clr", 1'b0, irq_q);
    endtask : t_irq

    // External trigger starts only when selected as a source.
    task automatic t_ext;
        wr(OFS_OPTION, 8'h00);
        @(negedge clock) ext_trigger = 1;
        repeat (3) @(negedge clock);
        chk("ext_off", 1'b0, adc_convert_q);
        ext_trigger = 0;
        wr(OFS_OPTION, 8'h02);
        @(negedge clock) ext_trigger = 1;
        repeat (3) @(negedge clock);
        chk("ext_on", 1'b1, adc_convert_q);
        ext_trigger = 0;
        wait_idle();
    endtask : t_ext

    // General purpose digital lines in both directions.
    task automatic t_dio;
        wr(OFS_DIO, 8'h0C);
        chk("dout", 4'hC, dig_out_q);
        rd(OFS_DIO);
        chk("din", 4'h9, d[3:0]);
    endtask : t_dio

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Main sequence.
    initial
    begin
        repeat (4) @(negedge clock);
        rst = 0;
        chk("rst_busy", 1'b0, adc_convert_q);
        chk("rst_irq", 1'b0, irq_q);
        t_soft();
        t_irq();
        t_ext();
        t_buf();
        t_ctr();
        t_pace();
        t_dio();
        finish_test();
    end

    // Watchdog: far beyond five conversions plus register traffic.
    initial
    begin
        #200000;
        errors++;
        finish_test();
    end
endmodule : adc_acquisition_control_test
